// [verilog/rbc_pkg.sv]
// constants, encodings and register map of the rotate/bit/call/return execution unit
`default_nettype none
package rbc_pkg;
  // register byte offsets on the axi4-lite bus
  localparam logic [7:0] OFF_CMD    = 8'h00;
  localparam logic [7:0] OFF_ACC    = 8'h04;
  localparam logic [7:0] OFF_PSW    = 8'h08;
  localparam logic [7:0] OFF_SP     = 8'h0c;
  localparam logic [7:0] OFF_PC     = 8'h10;
  localparam logic [7:0] OFF_PTR    = 8'h14;
  localparam logic [7:0] OFF_STATUS = 8'h18;
  // command word fields
  localparam int CMD_OP_LSB   = 0;
  localparam int CMD_KIND_LSB = 4;
  localparam int CMD_BIT_LSB  = 8;
  localparam int CMD_ADDR_LSB = 16;
  // status word fields
  localparam int ST_BUSY    = 0;
  localparam int ST_NONMASKABLE_IN_SERVICE_FLAG    = 1;
  localparam int ST_INHIBIT = 2;
  localparam int ST_ILLEGAL = 3;
  // processor status word bit positions
  localparam int PSW_CY = 0;
  localparam int PSW_AC = 4;
  localparam int PSW_Z  = 6;
  localparam int PSW_IE = 7;
  // values after reset
  localparam logic [7:0]  RST_ACC = 8'h00;
  localparam logic [7:0]  RST_PSW = 8'h00;
  localparam logic [15:0] RST_SP  = 16'h0000;
  localparam logic [15:0] RST_PC  = 16'h0000;
  localparam logic [15:0] RST_PTR = 16'h0000;
  // call table: upper eight address bits zero, then a fixed base pair, index, even byte
  localparam logic [7:0]  TBL_HIGH = 8'h00;
  localparam logic [1:0]  TBL_BASE = 2'b01;
  // return address offsets
  localparam logic [15:0] CALL_LEN  = 16'h0003;
  localparam logic [15:0] TABLE_SUBROUTINE_CALL_OP_LEN = 16'h0001;
  // bus responses
  localparam logic [1:0] RESP_OKAY   = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  typedef enum logic [3:0] {
    rotate_left_op                = 4'b0001,
    rotate_right_through_carry_op = 4'b0010,
    rotate_left_through_carry_op  = 4'b0011,
    single_bit_set_op             = 4'b0100,
    single_bit_clear_op           = 4'b0101,
    carry_invert_op               = 4'b0110,
    direct_subroutine_call_op     = 4'b0111,
    table_subroutine_call_op      = 4'b1000,
    subroutine_return_op          = 4'b1001,
    interrupt_return_op           = 4'b1010
  } rbc_op_e;

  typedef enum logic [2:0] {
    KIND_SHORT   = 3'b000,
    KIND_SPECIAL = 3'b001,
    KIND_ACC     = 3'b010,
    KIND_PSW     = 3'b011,
    KIND_POINTER = 3'b100,
    KIND_CARRY   = 3'b101
  } rbc_kind_e;

  typedef enum logic [3:0] {
    S_IDLE   = 4'b0000,
    S_EXEC   = 4'b0001,
    S_PUSH_H = 4'b0010,
    S_PUSH_L = 4'b0011,
    S_TBL_L  = 4'b0100,
    S_TBL_H  = 4'b0101,
    S_TBL_D  = 4'b0110,
    S_POP_L  = 4'b0111,
    S_POP_H  = 4'b1000,
    S_POP_P  = 4'b1001,
    S_POP_W  = 4'b1010,
    S_RMW_R  = 4'b1011,
    S_RMW_W  = 4'b1100
  } rbc_state_e;
endpackage
`default_nettype wire

// [verilog/rbc_exec.sv]
// execution unit for rotates, single-bit ops, calls and returns with an axi4-lite register port
//
// The AXI4-Lite slave port and the address map are this design's own decisions.
`default_nettype none
module rbc_exec (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  output logic [15:0]      dmem_addr,
  output logic [7:0]       dmem_wdata,
  output logic             dmem_we,
  output logic             dmem_re,
  input  wire logic [7:0]  dmem_rdata,
  output logic [15:0]      pmem_addr,
  output logic             pmem_re,
  input  wire logic [7:0]  pmem_rdata,
  input  wire logic        nmi_req,
  input  wire logic        irq_req,
  output logic             nmi_ack,
  output logic             irq_ack
);
  rbc_pkg::rbc_state_e state;
  logic [31:0] cmd;
  logic [7:0]  acc;
  logic [7:0]  processor_status_word;
  logic [15:0] sp;
  logic [15:0] pc;
  logic [15:0] ptr;
  logic [7:0]  tmp;
  logic        nonmaskable_in_service_flag;
  logic        inhibit;
  logic        illegal;
  logic        aw_held;
  logic        w_held;
  logic [7:0]  aw_addr;
  logic [31:0] w_data;
  logic [3:0]  w_strb;
  logic        wr_fire;
  logic        cmd_start;
  logic        can_ack;
  logic        done;
  logic [31:0] wr_word;
  logic [31:0] rd_word;
  logic        rd_hit;

  rbc_pkg::rbc_op_e   op;
  rbc_pkg::rbc_kind_e kind;
  logic [2:0]  bsel;
  logic [15:0] opaddr;
  logic [15:0] ret_addr;
  logic [15:0] tbl_addr;

  assign op       = rbc_pkg::rbc_op_e'(cmd[rbc_pkg::CMD_OP_LSB +: 4]);
  assign kind     = rbc_pkg::rbc_kind_e'(cmd[rbc_pkg::CMD_KIND_LSB +: 3]);
  assign bsel     = cmd[rbc_pkg::CMD_BIT_LSB +: 3];
  assign opaddr   = cmd[rbc_pkg::CMD_ADDR_LSB +: 16];
  assign tbl_addr = {rbc_pkg::TBL_HIGH, rbc_pkg::TBL_BASE, opaddr[4:0], 1'b0};
  assign ret_addr = (op == rbc_pkg::table_subroutine_call_op) ? pc + rbc_pkg::TABLE_SUBROUTINE_CALL_OP_LEN : pc + rbc_pkg::CALL_LEN;

  // write one chosen value into a single bit of a byte
  function automatic logic [7:0] put_bit(input logic [7:0] b, input logic [2:0] n, input logic v);
    logic [7:0] r;
    r    = b;
    r[n] = v;
    return r;
  endfunction

  // byte-lane merge of bus write data over the old register value
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d, input logic [3:0] s);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (s[i]) begin
        r[8*i +: 8] = d[8*i +: 8];
      end
    end
    return r;
  endfunction

  // write side: address and data are caught in either order, answered once both are held
  assign s_axi_awready = !aw_held && !s_axi_bvalid;
  assign s_axi_wready  = !w_held && !s_axi_bvalid;
  assign wr_fire       = aw_held && w_held && !s_axi_bvalid;
  assign cmd_start     = wr_fire && (aw_addr == rbc_pkg::OFF_CMD) && (state == rbc_pkg::S_IDLE);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held      <= 1'b0;
      w_held       <= 1'b0;
      aw_addr      <= 8'h00;
      w_data       <= 32'h0000_0000;
      w_strb       <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= rbc_pkg::RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end
      if (wr_fire) begin
        aw_held      <= 1'b0;
        w_held       <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= (aw_addr[1:0] == 2'b00 && aw_addr <= rbc_pkg::OFF_STATUS) ? rbc_pkg::RESP_OKAY
                                                                                : rbc_pkg::RESP_SLVERR;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // read side: one-cycle answer from a registered mux
  assign s_axi_arready = !s_axi_rvalid;
  always_comb begin
    rd_word = 32'h0000_0000;
    rd_hit  = 1'b1;
    unique case (s_axi_araddr)
      rbc_pkg::OFF_CMD:    rd_word = cmd;
      rbc_pkg::OFF_ACC:    rd_word = {24'h000000, acc};
      rbc_pkg::OFF_PSW:    rd_word = {24'h000000, processor_status_word};
      rbc_pkg::OFF_SP:     rd_word = {16'h0000, sp};
      rbc_pkg::OFF_PC:     rd_word = {16'h0000, pc};
      rbc_pkg::OFF_PTR:    rd_word = {16'h0000, ptr};
      rbc_pkg::OFF_STATUS: rd_word = {28'h0000000, illegal, inhibit, nonmaskable_in_service_flag, state != rbc_pkg::S_IDLE};
      default:             rd_hit  = 1'b0;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= rbc_pkg::RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= rd_word;
      s_axi_rresp  <= rd_hit ? rbc_pkg::RESP_OKAY : rbc_pkg::RESP_SLVERR;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // memory strobes follow the state; read data returns one cycle after the read strobe
  always_comb begin
    dmem_addr  = 16'h0000;
    dmem_wdata = 8'h00;
    dmem_we    = 1'b0;
    dmem_re    = 1'b0;
    pmem_addr  = 16'h0000;
    pmem_re    = 1'b0;
    unique case (state)
      rbc_pkg::S_PUSH_H: begin
        dmem_we    = 1'b1;
        dmem_addr  = sp - 16'h0001;
        dmem_wdata = ret_addr[15:8];
      end
      rbc_pkg::S_PUSH_L: begin
        dmem_we    = 1'b1;
        dmem_addr  = sp - 16'h0002;
        dmem_wdata = ret_addr[7:0];
      end
      rbc_pkg::S_TBL_L: begin
        pmem_re   = 1'b1;
        pmem_addr = tbl_addr;
      end
      rbc_pkg::S_TBL_H: begin
        pmem_re   = 1'b1;
        pmem_addr = tbl_addr + 16'h0001;
      end
      rbc_pkg::S_POP_L: begin
        dmem_re   = 1'b1;
        dmem_addr = sp;
      end
      rbc_pkg::S_POP_H: begin
        dmem_re   = 1'b1;
        dmem_addr = sp + 16'h0001;
      end
      rbc_pkg::S_POP_P: begin
        dmem_re   = (op == rbc_pkg::interrupt_return_op);
        dmem_addr = sp + 16'h0002;
      end
      rbc_pkg::S_RMW_R: begin
        dmem_re   = 1'b1;
        dmem_addr = (kind == rbc_pkg::KIND_POINTER) ? ptr : opaddr;
      end
      rbc_pkg::S_RMW_W: begin
        dmem_we    = 1'b1;
        dmem_addr  = (kind == rbc_pkg::KIND_POINTER) ? ptr : opaddr;
        dmem_wdata = put_bit(dmem_rdata, bsel, op == rbc_pkg::single_bit_set_op);
      end
      default: begin
      end
    endcase
  end

  assign wr_word = merge(32'h0000_0000, w_data, w_strb);

  // execution: state sequence and architectural registers together, bus writes only while idle
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state   <= rbc_pkg::S_IDLE;
      cmd     <= 32'h0000_0000;
      acc     <= rbc_pkg::RST_ACC;
      processor_status_word     <= rbc_pkg::RST_PSW;
      sp      <= rbc_pkg::RST_SP;
      pc      <= rbc_pkg::RST_PC;
      ptr     <= rbc_pkg::RST_PTR;
      tmp     <= 8'h00;
      illegal <= 1'b0;
      done    <= 1'b0;
    end else begin
      done <= 1'b0;
      unique case (state)
        rbc_pkg::S_IDLE: begin
          if (cmd_start) begin
            cmd     <= merge(cmd, w_data, w_strb);
            illegal <= 1'b0;
            state   <= rbc_pkg::S_EXEC;
          end else if (wr_fire) begin
            unique case (aw_addr)
              rbc_pkg::OFF_ACC: acc <= w_strb[0] ? wr_word[7:0] : acc;
              rbc_pkg::OFF_PSW: processor_status_word <= w_strb[0] ? wr_word[7:0] : processor_status_word;
              rbc_pkg::OFF_SP:  sp  <= wr_word[15:0] | (sp & ~{{8{w_strb[1]}}, {8{w_strb[0]}}});
              rbc_pkg::OFF_PC:  pc  <= wr_word[15:0] | (pc & ~{{8{w_strb[1]}}, {8{w_strb[0]}}});
              rbc_pkg::OFF_PTR: ptr <= wr_word[15:0] | (ptr & ~{{8{w_strb[1]}}, {8{w_strb[0]}}});
              default: begin
              end
            endcase
          end
        end
        rbc_pkg::S_EXEC: begin
          state <= rbc_pkg::S_IDLE;
          done  <= 1'b1;
          unique case (op)
            rbc_pkg::rotate_left_op: begin
              acc             <= {acc[6:0], acc[7]};
              processor_status_word[rbc_pkg::PSW_CY] <= acc[7];
            end
            rbc_pkg::rotate_right_through_carry_op: begin
              acc             <= {processor_status_word[rbc_pkg::PSW_CY], acc[7:1]};
              processor_status_word[rbc_pkg::PSW_CY] <= acc[0];
            end
            rbc_pkg::rotate_left_through_carry_op: begin
              acc             <= {acc[6:0], processor_status_word[rbc_pkg::PSW_CY]};
              processor_status_word[rbc_pkg::PSW_CY] <= acc[7];
            end
            rbc_pkg::single_bit_set_op, rbc_pkg::single_bit_clear_op: begin
              unique case (kind)
                rbc_pkg::KIND_ACC:   acc <= put_bit(acc, bsel, op == rbc_pkg::single_bit_set_op);
                rbc_pkg::KIND_PSW:   processor_status_word <= put_bit(processor_status_word, bsel, op == rbc_pkg::single_bit_set_op);
                rbc_pkg::KIND_CARRY: processor_status_word[rbc_pkg::PSW_CY] <= (op == rbc_pkg::single_bit_set_op);
                rbc_pkg::KIND_SHORT, rbc_pkg::KIND_SPECIAL, rbc_pkg::KIND_POINTER: begin
                  state <= rbc_pkg::S_RMW_R;
                  done  <= 1'b0;
                end
                default: illegal <= 1'b1;
              endcase
            end
            rbc_pkg::carry_invert_op: begin
              if (kind == rbc_pkg::KIND_CARRY) begin
                processor_status_word[rbc_pkg::PSW_CY] <= !processor_status_word[rbc_pkg::PSW_CY];
              end else begin
                illegal <= 1'b1;
              end
            end
            // calls and returns go through the stack
            rbc_pkg::direct_subroutine_call_op, rbc_pkg::table_subroutine_call_op: begin
              state <= rbc_pkg::S_PUSH_H;
              done  <= 1'b0;
            end
            rbc_pkg::subroutine_return_op, rbc_pkg::interrupt_return_op: begin
              state <= rbc_pkg::S_POP_L;
              done  <= 1'b0;
            end
            default: illegal <= 1'b1;
          endcase
        end
        rbc_pkg::S_PUSH_H: state <= rbc_pkg::S_PUSH_L;
        rbc_pkg::S_PUSH_L: begin
          sp <= sp - 16'h0002;
          if (op == rbc_pkg::direct_subroutine_call_op) begin
            pc    <= opaddr;
            state <= rbc_pkg::S_IDLE;
            done  <= 1'b1;
          end else begin
            state <= rbc_pkg::S_TBL_L;
          end
        end
        rbc_pkg::S_TBL_L: state <= rbc_pkg::S_TBL_H;
        rbc_pkg::S_TBL_H: begin
          tmp   <= pmem_rdata;
          state <= rbc_pkg::S_TBL_D;
        end
        rbc_pkg::S_TBL_D: begin
          pc    <= {pmem_rdata, tmp};
          state <= rbc_pkg::S_IDLE;
          done  <= 1'b1;
        end
        rbc_pkg::S_POP_L: state <= rbc_pkg::S_POP_H;
        rbc_pkg::S_POP_H: begin
          tmp   <= dmem_rdata;
          state <= rbc_pkg::S_POP_P;
        end
        rbc_pkg::S_POP_P: begin
          pc <= {dmem_rdata, tmp};
          if (op == rbc_pkg::interrupt_return_op) begin
            state <= rbc_pkg::S_POP_W;
          end else begin
            sp    <= sp + 16'h0002;
            state <= rbc_pkg::S_IDLE;
            done  <= 1'b1;
          end
        end
        rbc_pkg::S_POP_W: begin
          processor_status_word   <= dmem_rdata;
          sp    <= sp + 16'h0003;
          state <= rbc_pkg::S_IDLE;
          done  <= 1'b1;
        end
        rbc_pkg::S_RMW_R: state <= rbc_pkg::S_RMW_W;
        rbc_pkg::S_RMW_W: begin
          state <= rbc_pkg::S_IDLE;
          done  <= 1'b1;
        end
        default: state <= rbc_pkg::S_IDLE;
      endcase
    end
  end

  // acknowledge only between instructions; non-maskable wins over maskable
  // gating
  assign can_ack = (state == rbc_pkg::S_IDLE) && !cmd_start && !done && !inhibit && !nonmaskable_in_service_flag;
  assign nmi_ack = can_ack && nmi_req;
  assign irq_ack = can_ack && !nmi_req && irq_req && processor_status_word[rbc_pkg::PSW_IE];

  // in-service and post-return inhibit; acks never coincide with a finishing return
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      nonmaskable_in_service_flag    <= 1'b0;
      inhibit <= 1'b0;
    end else begin
      // set on non-maskable acknowledge, cleared by interrupt return
      if (done && op == rbc_pkg::interrupt_return_op) begin
        nonmaskable_in_service_flag    <= 1'b0;
        inhibit <= 1'b1;
      end else begin
        if (nmi_ack) begin
          nonmaskable_in_service_flag <= 1'b1;
        end
        if (done) begin
          inhibit <= 1'b0;
        end
      end
    end
  end

  property p_rol;
    @(posedge aclk) disable iff (!aresetn)
    (state == rbc_pkg::S_EXEC && op == rbc_pkg::rotate_left_op) |=>
      acc == {$past(acc[6:0]), $past(acc[7])} && processor_status_word[rbc_pkg::PSW_CY] == $past(acc[7]) && $stable(processor_status_word[6:1]);
  endproperty
  a_rol: assert property (p_rol) else $error("rotate left result wrong");

  property p_rotate_right_through_carry_op;
    @(posedge aclk) disable iff (!aresetn)
    (state == rbc_pkg::S_EXEC && op == rbc_pkg::rotate_right_through_carry_op) |=>
      acc == {$past(processor_status_word[0]), $past(acc[7:1])} && processor_status_word[rbc_pkg::PSW_CY] == $past(acc[0]);
  endproperty
  a_rotate_right_through_carry_op: assert property (p_rotate_right_through_carry_op) else $error("rotate right through carry wrong");

  property p_rotate_left_through_carry_op;
    @(posedge aclk) disable iff (!aresetn)
    (state == rbc_pkg::S_EXEC && op == rbc_pkg::rotate_left_through_carry_op) |=>
      acc == {$past(acc[6:0]), $past(processor_status_word[0])} && processor_status_word[rbc_pkg::PSW_CY] == $past(acc[7]);
  endproperty
  a_rotate_left_through_carry_op: assert property (p_rotate_left_through_carry_op) else $error("rotate left through carry wrong");

  property p_carry_only;
    @(posedge aclk) disable iff (!aresetn)
    (state == rbc_pkg::S_EXEC && kind == rbc_pkg::KIND_CARRY &&
     (op == rbc_pkg::single_bit_set_op || op == rbc_pkg::single_bit_clear_op || op == rbc_pkg::carry_invert_op)) |=>
      $stable(processor_status_word[7:1]) && $stable(acc) &&
      processor_status_word[0] == (($past(op) == rbc_pkg::carry_invert_op) ? !$past(processor_status_word[0]) : ($past(op) == rbc_pkg::single_bit_set_op));
  endproperty
  a_carry_only: assert property (p_carry_only) else $error("carry flag op touched other state");

  property p_call_push;
    @(posedge aclk) disable iff (!aresetn)
    (state == rbc_pkg::S_EXEC && op == rbc_pkg::direct_subroutine_call_op) |=>
      dmem_we && dmem_addr == sp - 16'h0001 ##1 dmem_we && dmem_addr == sp - 16'h0002
      ##1 pc == $past(opaddr) && sp == $past(sp, 2) - 16'h0002;
  endproperty
  a_call_push: assert property (p_call_push) else $error("direct call push or jump wrong");

  property p_ret_sp;
    @(posedge aclk) disable iff (!aresetn)
    (state == rbc_pkg::S_EXEC && op == rbc_pkg::subroutine_return_op) |=>
      ##3 sp == $past(sp, 3) + 16'h0002 && state == rbc_pkg::S_IDLE && $stable(processor_status_word);
  endproperty
  a_ret_sp: assert property (p_ret_sp) else $error("return stack pointer wrong");

  property p_interrupt_return_op;
    @(posedge aclk) disable iff (!aresetn)
    (state == rbc_pkg::S_POP_W) |=> sp == $past(sp) + 16'h0003 && processor_status_word == $past(dmem_rdata)
      ##1 !nonmaskable_in_service_flag && inhibit;
  endproperty
  a_interrupt_return_op: assert property (p_interrupt_return_op) else $error("interrupt return did not restore");

  property p_no_ack;
    @(posedge aclk) disable iff (!aresetn)
    (nonmaskable_in_service_flag || inhibit) |-> !nmi_ack && !irq_ack;
  endproperty
  a_no_ack: assert property (p_no_ack) else $error("interrupt taken while blocked");

  property p_nonmaskable_in_service_flag_set;
    @(posedge aclk) disable iff (!aresetn)
    nmi_ack |=> nonmaskable_in_service_flag;
  endproperty
  a_nonmaskable_in_service_flag_set: assert property (p_nonmaskable_in_service_flag_set) else $error("in-service flag not set");
endmodule // rbc_exec
`default_nettype wire

// [tb/tb_rbc_exec.sv]
// self-checking bench for the rotate/bit/call/return execution unit
`default_nettype none
module tb_rbc_exec;
  timeunit 1ns;
  timeprecision 1ns;
  logic        aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
  logic        s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, dmem_we, dmem_re;
  logic        pmem_re, nmi_req, irq_req, nmi_ack, irq_ack;
  logic [7:0]  s_axi_awaddr, s_axi_araddr, dmem_wdata, dmem_rdata, pmem_rdata;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic [15:0] dmem_addr, pmem_addr;
  logic [7:0]  dmem [0:65535];
  logic [7:0]  pmem [0:255];
  int          err_total, checks, irq_n, nmi_n;
  logic [1:0]  last_bresp;

  rbc_exec i_rbc_exec (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .dmem_addr,
    .dmem_wdata, .dmem_we, .dmem_re, .dmem_rdata, .pmem_addr, .pmem_re, .pmem_rdata, .nmi_req, .irq_req,
    .nmi_ack, .irq_ack);

  initial begin
    aclk = 1'b0;
    forever #25 aclk = ~aclk;
  end

  // one-cycle memories; an idle port toggles so stale data cannot pass
  always @(posedge aclk) begin
    if (dmem_we) dmem[dmem_addr] <= dmem_wdata;
    dmem_rdata <= dmem_re ? dmem[dmem_addr] : ~dmem_rdata;
    pmem_rdata <= pmem_re ? pmem[pmem_addr[7:0]] : ~pmem_rdata;
  end

  // acks counted at the falling edge, where they are settled
  always @(negedge aclk) begin
    if (irq_ack === 1'b1) irq_n++;
    if (nmi_ack === 1'b1) nmi_n++;
  end

  task automatic finish_test();
    if (err_total == 0 && checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks++;
    if (g !== e) begin
      err_total++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask

  // handshakes judged at the falling edge, released after the rising edge
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic ha, hw, hb;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    for (int n = 0; n < 40; n++) begin
      @(negedge aclk);
      ha = s_axi_awvalid & s_axi_awready;
      hw = s_axi_wvalid & s_axi_wready;
      hb = s_axi_bvalid;
      last_bresp = s_axi_bresp;
      @(posedge aclk);
      if (ha) s_axi_awvalid <= 1'b0;
      if (hw) s_axi_wvalid <= 1'b0;
      if (hb) begin
        s_axi_bready <= 1'b0;
        @(posedge aclk);
        return;
      end
    end
    err_total++;
    finish_test();
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    logic ha, hr;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    for (int n = 0; n < 40; n++) begin
      @(negedge aclk);
      ha = s_axi_arvalid & s_axi_arready;
      hr = s_axi_rvalid;
      d = s_axi_rdata;
      r = s_axi_rresp;
      @(posedge aclk);
      if (ha) s_axi_arvalid <= 1'b0;
      if (hr) begin
        s_axi_rready <= 1'b0;
        @(posedge aclk);
        return;
      end
    end
    err_total++;
    finish_test();
  endtask

  task automatic rchk(input string nm, input logic [7:0] a, input logic [31:0] e);
    logic [31:0] d;
    logic [1:0]  r;
    rd(a, d, r);
    chk(nm, e, d);
  endtask

  // issue a command, then poll busy with a bound
  task automatic run(input logic [3:0] op, input logic [2:0] k, input logic [2:0] b, input logic [15:0] ad);
    logic [31:0] s;
    logic [1:0]  r;
    wr(rbc_pkg::OFF_CMD, {ad, 5'h00, b, 1'b0, k, op});
    for (int n = 0; n < 20; n++) begin
      rd(rbc_pkg::OFF_STATUS, s, r);
      if (s[rbc_pkg::ST_BUSY] === 1'b0) return;
    end
    err_total++;
    finish_test();
  endtask

  task automatic step(input logic [3:0] op, input logic [2:0] k, input logic [2:0] b, input logic [15:0] ad,
                      input logic [7:0] ea, input logic [7:0] ep);
    run(op, k, b, ad);
    rchk("acc", rbc_pkg::OFF_ACC, {24'h0, ea});
    rchk("psw", rbc_pkg::OFF_PSW, {24'h0, ep});
  endtask

  task automatic t_bus();
    logic [31:0] d;
    logic [1:0]  r;
    rchk("sp", rbc_pkg::OFF_SP, 32'h0);
    rd(8'h1c, d, r);
    chk("rresp", {30'h0, rbc_pkg::RESP_SLVERR}, {30'h0, r});
    wr(8'h1c, 32'h0);
    chk("bresp", {30'h0, rbc_pkg::RESP_SLVERR}, {30'h0, last_bresp});
  endtask

  task automatic t_rot();
    wr(rbc_pkg::OFF_ACC, 32'h96);
    wr(rbc_pkg::OFF_PSW, 32'h50);
    step(rbc_pkg::rotate_left_op, 3'h0, 3'h0, 16'h0, 8'h2d, 8'h51);
    wr(rbc_pkg::OFF_ACC, 32'h2c);
    step(rbc_pkg::rotate_right_through_carry_op, 3'h0, 3'h0, 16'h0, 8'h96, 8'h50);
    step(rbc_pkg::rotate_left_through_carry_op, 3'h0, 3'h0, 16'h0, 8'h2c, 8'h51);
  endtask

  task automatic t_bit();
    step(rbc_pkg::single_bit_set_op, rbc_pkg::KIND_ACC, 3'h0, 16'h0, 8'h2d, 8'h51);
    step(rbc_pkg::single_bit_clear_op, rbc_pkg::KIND_ACC, 3'h3, 16'h0, 8'h25, 8'h51);
    step(rbc_pkg::single_bit_set_op, rbc_pkg::KIND_PSW, 3'h7, 16'h0, 8'h25, 8'hd1);
    step(rbc_pkg::single_bit_clear_op, rbc_pkg::KIND_PSW, 3'h6, 16'h0, 8'h25, 8'h91);
    step(rbc_pkg::single_bit_clear_op, rbc_pkg::KIND_CARRY, 3'h0, 16'h0, 8'h25, 8'h90);
    step(rbc_pkg::single_bit_set_op, rbc_pkg::KIND_CARRY, 3'h0, 16'h0, 8'h25, 8'h91);
    step(rbc_pkg::carry_invert_op, rbc_pkg::KIND_CARRY, 3'h0, 16'h0, 8'h25, 8'h90);
    step(rbc_pkg::single_bit_set_op, rbc_pkg::KIND_SHORT, 3'h1, 16'h0fe5, 8'h25, 8'h90);
    step(rbc_pkg::single_bit_set_op, rbc_pkg::KIND_SPECIAL, 3'h7, 16'hff20, 8'h25, 8'h90);
    chk("mem", 32'h028f, {16'h0, dmem[16'h0fe5], dmem[16'hff20]});
    wr(rbc_pkg::OFF_PTR, 32'h0fe5);
    step(rbc_pkg::single_bit_clear_op, rbc_pkg::KIND_POINTER, 3'h1, 16'h0, 8'h25, 8'h90);
    chk("mem", 32'h0, {24'h0, dmem[16'h0fe5]});
  endtask

  task automatic t_call();
    wr(rbc_pkg::OFF_SP, 32'h0001);
    wr(rbc_pkg::OFF_PC, 32'h1234);
    step(rbc_pkg::direct_subroutine_call_op, 3'h0, 3'h0, 16'habcd, 8'h25, 8'h90);
    chk("push", 32'h1237, {16'h0, dmem[16'h0000], dmem[16'hffff]});
    rchk("sp", rbc_pkg::OFF_SP, 32'hffff);
    rchk("pc", rbc_pkg::OFF_PC, 32'habcd);
    step(rbc_pkg::table_subroutine_call_op, 3'h0, 3'h0, 16'h0003, 8'h25, 8'h90);
    chk("push", 32'habce, {16'h0, dmem[16'hfffe], dmem[16'hfffd]});
    rchk("sp", rbc_pkg::OFF_SP, 32'hfffd);
    rchk("pc", rbc_pkg::OFF_PC, 32'h5678);
    step(rbc_pkg::subroutine_return_op, 3'h0, 3'h0, 16'h0, 8'h25, 8'h90);
    rchk("pc", rbc_pkg::OFF_PC, 32'habce);
    step(rbc_pkg::subroutine_return_op, 3'h0, 3'h0, 16'h0, 8'h25, 8'h90);
    rchk("sp", rbc_pkg::OFF_SP, 32'h0001);
    rchk("pc", rbc_pkg::OFF_PC, 32'h1237);
  endtask

  // interrupts enabled in the status word, so only the flags can hold irq back
  task automatic t_nmi();
    nmi_req <= 1'b1;
    for (int n = 0; n < 20 && nmi_n == 0; n++) @(posedge aclk);
    nmi_req <= 1'b0;
    chk("nmi_ack", 32'h1, {31'h0, nmi_n != 0});
    irq_req <= 1'b1;
    rchk("status", rbc_pkg::OFF_STATUS, 32'h2);
    repeat (20) @(posedge aclk);
    chk("irq_ack", 32'h0, irq_n);
    wr(rbc_pkg::OFF_SP, 32'h0200);
    step(rbc_pkg::interrupt_return_op, 3'h0, 3'h0, 16'h0, 8'h25, 8'h85);
    rchk("sp", rbc_pkg::OFF_SP, 32'h0203);
    rchk("pc", rbc_pkg::OFF_PC, 32'h1122);
    rchk("status", rbc_pkg::OFF_STATUS, 32'h4);
    repeat (10) @(posedge aclk);
    chk("irq_ack", 32'h0, irq_n);
    run(rbc_pkg::carry_invert_op, rbc_pkg::KIND_CARRY, 3'h0, 16'h0);
    for (int n = 0; n < 20 && irq_n == 0; n++) @(posedge aclk);
    irq_req <= 1'b0;
    chk("irq_ack", 32'h1, {31'h0, irq_n != 0});
  endtask

  initial begin
    {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready, nmi_req, irq_req} = 8'h00;
    {s_axi_awaddr, s_axi_araddr, dmem_rdata, pmem_rdata, s_axi_wdata} = 64'h0;
    s_axi_wstrb = 4'hf;
    for (int i = 0; i < 65536; i++) dmem[i] = 8'h00;
    for (int i = 0; i < 256; i++) pmem[i] = 8'h00;
    dmem[16'hff20] = 8'h0f;
    {dmem[16'h0202], dmem[16'h0201], dmem[16'h0200]} = 24'h851122;
    {pmem[8'h47], pmem[8'h46]} = 16'h5678;
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    t_bus();
    t_rot();
    t_bit();
    t_call();
    t_nmi();
    finish_test();
  end
endmodule // tb_rbc_exec
`default_nettype wire
